// file: clo_ctrl.sv
// Display controller end: cursor shape, cursor stepping and layer overlay setup.
//
// Contract
// - Width field is cursor pixels minus one.
// - Host keeps width within horizontal character size.
// - Shape bit zero underscore, one block.
// - Host sets block cursor in graphics mode.
// - Height is underscore row or block height.
// - Height field is lines minus one.
// - Host keeps height within vertical character size.
// - Cursor steps after every memory access.
// - Sideways one character, vertical by pitch.
// - 00 right 01 left 10 up 11 down.
// - Steps are address units, even size nine.
// - Three-layer bit picks two or three layers.
// - Host clears three-layer bit for mixed text.
// - Block 3 text or graphics by bit 3.
// - Block 1 text or graphics by bit 2.
// - Blocks 2 and 4 always graphics.
// - Combine codes OR, XOR-OR, AND-OR, reserved.
// - One combining method per layer.
// - Text first layer disables third; others graphics.
// - Shape command takes width and height registers.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module clo_ctrl
  import clo_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Host link.
  clo_if.ctrl bus,
  // Pixels of the three layers at the current position.
  input wire logic first_layer,
  input wire logic second_layer,
  input wire logic third_layer,
  // Decoded display setup.
  output logic [4:0] cursor_horiz_extent,
  output logic [4:0] cursor_vert_extent,
  output logic cursor_shape_select,
  output logic underline_mode,
  output logic [1:0] layer_count,
  output logic [3:0] block_graphics,
  output logic [15:0] cursor_addr,
  output logic pix_out
);
  logic [7:0] width_q;
  logic [7:0] height_q;
  logic [7:0] step_q;
  logic [7:0] layer_q;
  logic [7:0] hsize_q;
  logic [7:0] vsize_q;
  logic [15:0] pitch_q;
  logic [15:0] addr_q;
  logic [15:0] addr_d;
  logic [7:0] rdata_q;
  logic pix_d;

  // Next cursor address for a given step direction.
  function automatic logic [15:0] step_addr(input logic [15:0] a, input logic [1:0] dir,
                                            input logic [15:0] pitch);
    case (dir)
      CLO_DIR_RIGHT: step_addr = a + 16'h0001;
      CLO_DIR_LEFT: step_addr = a - 16'h0001;
      CLO_DIR_UP: step_addr = a - pitch;
      default: step_addr = a + pitch;
    endcase
  endfunction : step_addr

  // Cursor shape registers, loaded by register writes or the shape command.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      width_q <= CLO_RST_BYTE;
      height_q <= CLO_RST_BYTE;
    end
    else if (bus.cmd && bus.cmd_code == CLO_CMD_SHAPE)
    begin
      width_q <= bus.cmd_par[7:0] & CLO_NIB_MASK;
      height_q <= bus.cmd_par[15:8] & CLO_SHAPE_MASK;
    end
    else if (bus.wr && bus.addr == CLO_REG_CURSOR_WIDTH)
      width_q <= bus.wdata & CLO_NIB_MASK;
    else if (bus.wr && bus.addr == CLO_REG_CURSOR_HEIGHT)
      height_q <= bus.wdata & CLO_SHAPE_MASK;
  end

  // Step direction, from register writes or the four direction commands.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      step_q <= CLO_RST_BYTE;
    else if (bus.cmd && bus.cmd_code[7:2] == CLO_CMD_STEP_BASE[7:2])
      step_q <= {6'b000000, bus.cmd_code[1:0]};
    else if (bus.wr && bus.addr == CLO_REG_CURSOR_STEP)
      step_q <= bus.wdata & CLO_STEP_MASK;
  end

  // Layer setup, from register writes or the layer command.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      layer_q <= CLO_RST_BYTE;
    else if (bus.cmd && bus.cmd_code == CLO_CMD_LAYER)
      layer_q <= bus.cmd_par[7:0] & CLO_LAYER_MASK;
    else if (bus.wr && bus.addr == CLO_REG_LAYER_SETUP)
      layer_q <= bus.wdata & CLO_LAYER_MASK;
  end

  // Character size and address pitch that the cursor logic depends on.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hsize_q <= CLO_RST_BYTE;
      vsize_q <= CLO_RST_BYTE;
      pitch_q <= CLO_RST_WORD;
    end
    else if (bus.wr)
    begin
      if (bus.addr == CLO_REG_CHAR_HSIZE)
        hsize_q <= bus.wdata;
      if (bus.addr == CLO_REG_CHAR_VSIZE)
        vsize_q <= bus.wdata;
      if (bus.addr == CLO_REG_PITCH_LO)
        pitch_q[7:0] <= bus.wdata;
      if (bus.addr == CLO_REG_PITCH_HI)
        pitch_q[15:8] <= bus.wdata;
    end
  end

  // Cursor address: set by writes, stepped after every memory access.
  always_comb
  begin
    addr_d = addr_q;
    if (bus.mem_acc)
      addr_d = step_addr(addr_q, step_q[1:0], pitch_q);
    else if (bus.wr && bus.addr == CLO_REG_CURSOR_LO)
      addr_d = {addr_q[15:8], bus.wdata};
    else if (bus.wr && bus.addr == CLO_REG_CURSOR_HI)
      addr_d = {bus.wdata, addr_q[7:0]};
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      addr_q <= CLO_RST_WORD;
    else
      addr_q <= addr_d;
  end

  // Read data, valid the cycle after the read strobe; unmapped reads give zero.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= CLO_RST_BYTE;
    else if (bus.rd)
    begin
      case (bus.addr)
        CLO_REG_CURSOR_WIDTH: rdata_q <= width_q;
        CLO_REG_CURSOR_HEIGHT: rdata_q <= height_q;
        CLO_REG_CURSOR_STEP: rdata_q <= step_q;
        CLO_REG_LAYER_SETUP: rdata_q <= layer_q;
        CLO_REG_CHAR_HSIZE: rdata_q <= hsize_q;
        CLO_REG_CHAR_VSIZE: rdata_q <= vsize_q;
        CLO_REG_PITCH_LO: rdata_q <= pitch_q[7:0];
        CLO_REG_PITCH_HI: rdata_q <= pitch_q[15:8];
        CLO_REG_CURSOR_RD_LO: rdata_q <= addr_q[7:0];
        CLO_REG_CURSOR_RD_HI: rdata_q <= addr_q[15:8];
        default: rdata_q <= CLO_RST_BYTE;
      endcase
    end
  end
  assign bus.rdata = rdata_q;

  // Decoded cursor shape.
  assign cursor_horiz_extent = {1'b0, width_q[3:0]} + 5'd1;
  assign cursor_vert_extent = {1'b0, height_q[3:0]} + 5'd1;
  assign cursor_shape_select = height_q[CLO_SHAPE_BIT];
  assign underline_mode = ~height_q[CLO_SHAPE_BIT];
  assign cursor_addr = addr_q;

  // Decoded layer setup; bit order is blocks 4,3,2,1.
  assign layer_count = layer_q[CLO_THREE_BIT] ? 2'd3 : 2'd2;
  assign block_graphics = {1'b1, layer_q[CLO_BLK3_BIT], 1'b1, layer_q[CLO_BLK1_BIT]};

  clo_mix u_mix (
    .mix(clo_mix_t'(layer_q[1:0])),
    .three_en(layer_q[CLO_THREE_BIT]),
    .first_text(~layer_q[CLO_BLK1_BIT]),
    .first_layer(first_layer),
    .second_layer(second_layer),
    .third_layer(third_layer),
    .pix(pix_d)
  );

  // Composed pixel leaves through a flip-flop.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pix_out <= 1'b0;
    else
      pix_out <= pix_d;
  end
endmodule : clo_ctrl
`default_nettype wire

// file: clo_host.sv
// Host end: passes software orders to the controller and enforces host-side limits.
`timescale 1ns/1ps
`default_nettype none
module clo_host
  import clo_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Software port.
  input wire logic [7:0] sw_addr,
  input wire logic [7:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [7:0] sw_rdata,
  // Software commands.
  input wire logic sw_cmd,
  input wire logic [7:0] sw_cmd_code,
  input wire logic sw_mem_acc,
  input wire logic graphics_mode,
  // Link to controller.
  clo_if.host bus
);
  logic [7:0] hsize_q;
  logic [7:0] vsize_q;
  logic [7:0] width_q;
  logic [7:0] height_q;
  logic [7:0] layer_q;
  logic [7:0] wdata_d;

  // Shadow copies used to clamp writes and build command parameters.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hsize_q <= CLO_RST_BYTE;
      vsize_q <= CLO_RST_BYTE;
      width_q <= CLO_RST_BYTE;
      height_q <= CLO_RST_BYTE;
      layer_q <= CLO_RST_BYTE;
    end
    else if (sw_wr)
    begin
      if (sw_addr == CLO_REG_CHAR_HSIZE)
        hsize_q <= sw_wdata;
      if (sw_addr == CLO_REG_CHAR_VSIZE)
        vsize_q <= sw_wdata;
      if (sw_addr == CLO_REG_CURSOR_WIDTH)
        width_q <= wdata_d;
      if (sw_addr == CLO_REG_CURSOR_HEIGHT)
        height_q <= wdata_d;
      if (sw_addr == CLO_REG_LAYER_SETUP)
        layer_q <= wdata_d;
    end
  end

  // Clamp fields and clear unused bits before they leave.
  always_comb
  begin
    wdata_d = sw_wdata;
    case (sw_addr)
      CLO_REG_CURSOR_WIDTH:
        wdata_d = (sw_wdata[3:0] > hsize_q[3:0]) ? {4'h0, hsize_q[3:0]}
                                                 : (sw_wdata & CLO_NIB_MASK);
      CLO_REG_CURSOR_HEIGHT:
      begin
        wdata_d = sw_wdata & CLO_SHAPE_MASK;
        if (sw_wdata[3:0] > vsize_q[3:0])
          wdata_d[3:0] = vsize_q[3:0];
        if (graphics_mode)
          wdata_d[CLO_SHAPE_BIT] = 1'b1;
      end
      CLO_REG_CURSOR_STEP: wdata_d = sw_wdata & CLO_STEP_MASK;
      CLO_REG_LAYER_SETUP:
      begin
        wdata_d = sw_wdata & CLO_LAYER_MASK;
        if (wdata_d[1:0] == 2'b11)
          wdata_d[1:0] = 2'b00;
        if (!(wdata_d[CLO_BLK1_BIT] && wdata_d[CLO_BLK3_BIT]))
          wdata_d[CLO_THREE_BIT] = 1'b0;
      end
      default: wdata_d = sw_wdata;
    endcase
  end

  // Link outputs change only on clock edges.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus.addr <= CLO_RST_BYTE;
      bus.wdata <= CLO_RST_BYTE;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      bus.cmd <= 1'b0;
      bus.cmd_code <= CLO_RST_BYTE;
      bus.cmd_par <= CLO_RST_WORD;
      bus.mem_acc <= 1'b0;
    end
    else
    begin
      bus.addr <= sw_addr;
      bus.wdata <= wdata_d;
      bus.wr <= sw_wr;
      bus.rd <= sw_rd & ~sw_wr;
      bus.cmd <= sw_cmd;
      bus.cmd_code <= sw_cmd_code;
      // The layer command carries the layer setup; every other command the cursor shape.
      if (sw_cmd_code == CLO_CMD_LAYER)
        bus.cmd_par <= {CLO_RST_BYTE, layer_q};
      else
        bus.cmd_par <= {height_q, width_q};
      bus.mem_acc <= sw_mem_acc;
    end
  end

  assign sw_rdata = bus.rdata;
endmodule : clo_host
`default_nettype wire

// file: clo_if.sv
// Interface joining the host end to the display controller end.
`timescale 1ns/1ps
`default_nettype none
interface clo_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic cmd;
  logic [7:0] cmd_code;
  logic [15:0] cmd_par;
  logic mem_acc;
  modport ctrl (input addr, input wdata, input wr, input rd, output rdata,
    input cmd, input cmd_code, input cmd_par, input mem_acc);
  modport host (output addr, output wdata, output wr, output rd, input rdata,
    output cmd, output cmd_code, output cmd_par, output mem_acc);
endinterface : clo_if
`default_nettype wire

// file: clo_link_props.sv
// Checker of the link between the host end and the controller end.
`timescale 1ns/1ps
`default_nettype none
module clo_link_props
  import clo_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Link signals.
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic cmd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_par,
  input wire logic mem_acc
);
  logic [7:0] hs_q, vs_q, w_q, h_q, l_q;

  // Shadow copies of the last values the host wrote across the link.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hs_q <= 8'h00;
      vs_q <= 8'h00;
      w_q <= 8'h00;
      h_q <= 8'h00;
      l_q <= 8'h00;
    end
    else if (wr)
    begin
      if (addr == CLO_REG_CHAR_HSIZE) hs_q <= wdata;
      if (addr == CLO_REG_CHAR_VSIZE) vs_q <= wdata;
      if (addr == CLO_REG_CURSOR_WIDTH) w_q <= wdata;
      if (addr == CLO_REG_CURSOR_HEIGHT) h_q <= wdata;
      if (addr == CLO_REG_LAYER_SETUP) l_q <= wdata;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // A read or a write of one register index.
  sequence s_rd(logic [7:0] a);
    rd && addr == a;
  endsequence
  sequence s_wr(logic [7:0] a);
    wr && addr == a;
  endsequence

  property p_width_rd;
    s_rd(CLO_REG_CURSOR_WIDTH) |=> rdata == (w_q & CLO_NIB_MASK);
  endproperty
  a_width_rd: assert property (p_width_rd)
    else $error("cursor width read back wrong");
  property p_height_rd;
    s_rd(CLO_REG_CURSOR_HEIGHT) |=> rdata == (h_q & CLO_SHAPE_MASK);
  endproperty
  a_height_rd: assert property (p_height_rd)
    else $error("cursor height read back wrong");
  property p_layer_rd;
    s_rd(CLO_REG_LAYER_SETUP) |=> rdata == (l_q & CLO_LAYER_MASK);
  endproperty
  a_layer_rd: assert property (p_layer_rd)
    else $error("layer setup read back wrong");
  property p_rsvd;
    s_wr(CLO_REG_LAYER_SETUP) |-> wdata[1:0] != 2'h3;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved combine code sent");
  property p_three;
    s_wr(CLO_REG_LAYER_SETUP) && wdata[4] |-> wdata[3:2] == 2'h3;
  endproperty
  a_three: assert property (p_three)
    else $error("three layers with a text block");
  property p_wclamp;
    s_wr(CLO_REG_CURSOR_WIDTH) |-> wdata[3:0] <= hs_q[3:0];
  endproperty
  a_wclamp: assert property (p_wclamp)
    else $error("cursor wider than character");
  property p_hclamp;
    s_wr(CLO_REG_CURSOR_HEIGHT) |-> wdata[3:0] <= vs_q[3:0];
  endproperty
  a_hclamp: assert property (p_hclamp)
    else $error("cursor taller than character");
  property p_shape_par;
    cmd && cmd_code == CLO_CMD_SHAPE |-> cmd_par[3:0] == w_q[3:0] && cmd_par[11:8] == h_q[3:0];
  endproperty
  a_shape_par: assert property (p_shape_par)
    else $error("shape command parameters differ from registers");
  property p_layer_par;
    cmd && cmd_code == CLO_CMD_LAYER |-> cmd_par[7:0] == l_q;
  endproperty
  a_layer_par: assert property (p_layer_par)
    else $error("layer command parameter differs from register");
endmodule : clo_link_props
`default_nettype wire

// file: clo_mix.sv
// Layer combiner for one pixel column of the three layers.
`timescale 1ns/1ps
`default_nettype none
module clo_mix
  import clo_pkg::*;
(
  // Setup.
  input wire clo_pkg::clo_mix_t mix,
  input wire logic three_en,
  input wire logic first_text,
  // Layer pixels.
  input wire logic first_layer,
  input wire logic second_layer,
  input wire logic third_layer,
  // Result.
  output logic pix
);
  logic l3;
  // Third layer is dropped when only two layers run or the first holds text.
  assign l3 = third_layer & three_en & ~first_text;
  // One method for all blocks of a layer; reserved code shows nothing.
  always_comb
  begin
    case (mix)
      CLO_MIX_OR: pix = first_layer | second_layer | l3;
      CLO_MIX_XOR: pix = (first_layer ^ second_layer) | l3;
      CLO_MIX_AND: pix = (first_layer & second_layer) | l3;
      default: pix = 1'b0;
    endcase
  end
endmodule : clo_mix
`default_nettype wire

// file: clo_pkg.sv
// Package of register offsets, field positions and codes for the cursor and overlay block.
package clo_pkg;
  localparam logic [7:0] CLO_REG_CURSOR_WIDTH = 8'h15;
  localparam logic [7:0] CLO_REG_CURSOR_HEIGHT = 8'h16;
  localparam logic [7:0] CLO_REG_CURSOR_STEP = 8'h17;
  localparam logic [7:0] CLO_REG_LAYER_SETUP = 8'h18;
  localparam logic [7:0] CLO_REG_CHAR_HSIZE = 8'h01;
  localparam logic [7:0] CLO_REG_CHAR_VSIZE = 8'h02;
  localparam logic [7:0] CLO_REG_PITCH_LO = 8'h06;
  localparam logic [7:0] CLO_REG_PITCH_HI = 8'h07;
  localparam logic [7:0] CLO_REG_CURSOR_LO = 8'h1c;
  localparam logic [7:0] CLO_REG_CURSOR_HI = 8'h1d;
  localparam logic [7:0] CLO_REG_CURSOR_RD_LO = 8'h1e;
  localparam logic [7:0] CLO_REG_CURSOR_RD_HI = 8'h1f;
  localparam logic [7:0] CLO_RST_BYTE = 8'h00;
  localparam logic [15:0] CLO_RST_WORD = 16'h0000;
  localparam int CLO_SHAPE_BIT = 7;
  localparam int CLO_THREE_BIT = 4;
  localparam int CLO_BLK3_BIT = 3;
  localparam int CLO_BLK1_BIT = 2;
  localparam logic [7:0] CLO_NIB_MASK = 8'h0f;
  localparam logic [7:0] CLO_SHAPE_MASK = 8'h8f;
  localparam logic [7:0] CLO_STEP_MASK = 8'h03;
  localparam logic [7:0] CLO_LAYER_MASK = 8'h1f;
  localparam logic [7:0] CLO_CMD_SHAPE = 8'h5d;
  localparam logic [7:0] CLO_CMD_STEP_BASE = 8'h4c;
  localparam logic [7:0] CLO_CMD_LAYER = 8'h5b;
  localparam logic [7:0] CLO_CMD_MEM = 8'h42;
  // Step direction codes.
  typedef enum logic [1:0] {CLO_DIR_RIGHT, CLO_DIR_LEFT, CLO_DIR_UP, CLO_DIR_DOWN} clo_dir_t;
  // Layer combining codes.
  typedef enum logic [1:0] {CLO_MIX_OR, CLO_MIX_XOR, CLO_MIX_AND, CLO_MIX_RSVD} clo_mix_t;
endpackage : clo_pkg

// file: tb.sv
// Self-checking testbench of the host and controller ends.
`timescale 1ns/1ps
`default_nettype none
module tb
  import clo_pkg::*;
;
  logic clk, rstn, wr, rd, cmd, macc, gmode, l1, l2, l3, pix, shp, und;
  logic [7:0] a, wd, rdat, cc;
  logic [4:0] hx, vx;
  logic [1:0] lc;
  logic [3:0] bg;
  logic [15:0] ca, exp;
  int err_count, n_compared, cyc;
  // Rows: combine code, first, second, third layer pixel, expected pixel.
  localparam logic [5:0] ROWS [11] = '{6'h00, 6'h09, 6'h03, 6'h1c, 6'h19, 6'h13, 6'h15,
    6'h2d, 6'h28, 6'h2f, 6'h2b};

  clo_if lnk ();
  clo_host i_clo_host (.clk(clk), .rstn(rstn), .sw_addr(a), .sw_wdata(wd), .sw_wr(wr),
    .sw_rd(rd), .sw_rdata(rdat), .sw_cmd(cmd), .sw_cmd_code(cc), .sw_mem_acc(macc),
    .graphics_mode(gmode), .bus(lnk));
  clo_ctrl i_clo_ctrl (.clk(clk), .rstn(rstn), .bus(lnk), .first_layer(l1),
    .second_layer(l2), .third_layer(l3), .cursor_horiz_extent(hx), .cursor_vert_extent(vx),
    .cursor_shape_select(shp), .underline_mode(und), .layer_count(lc),
    .block_graphics(bg), .cursor_addr(ca), .pix_out(pix));
  clo_link_props i_clo_link_props (.clk(clk), .rstn(rstn), .addr(lnk.addr),
    .wdata(lnk.wdata), .wr(lnk.wr), .rd(lnk.rd), .rdata(lnk.rdata), .cmd(lnk.cmd),
    .cmd_code(lnk.cmd_code), .cmd_par(lnk.cmd_par), .mem_acc(lnk.mem_acc));

  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (e !== g)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One write cycle on the software port.
  task automatic wreg(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    a <= ad;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg

  // One read cycle; the data are checked once the host has passed them on.
  task automatic rreg(input logic [7:0] ad, input logic [7:0] e);
    @(posedge clk);
    a <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("rdata", e, rdat);
  endtask : rreg

  // A command pulse, or a memory access pulse when c is low.
  task automatic pulse(input logic c, input logic [7:0] code);
    @(posedge clk);
    cc <= code;
    cmd <= c;
    macc <= !c;
    @(posedge clk);
    cmd <= 1'b0;
    macc <= 1'b0;
  endtask : pulse

  // Lets the host and controller stages settle.
  task automatic settle();
    repeat (4) @(posedge clk);
    @(negedge clk);
  endtask : settle

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  // Clock of 50 ns period.
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Cuts a hang short.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_count++;
      end_sim();
    end
  end

  // Main sequence.
  initial
  begin
    {rstn, wr, rd, cmd, macc, gmode, l1, l2, l3} = '0;
    {a, wd, cc} = '0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk("lcount", 2'h2, lc);
    chk("blocks", 4'ha, bg);
    chk("hext", 5'h01, hx);
    chk("under", 1'b1, und);
    rreg(CLO_REG_CURSOR_HEIGHT, 8'h00);
    wreg(CLO_REG_CHAR_HSIZE, 8'h0f);
    wreg(CLO_REG_CHAR_VSIZE, 8'h0f);
    wreg(CLO_REG_CURSOR_WIDTH, 8'hf7);
    wreg(CLO_REG_CURSOR_HEIGHT, 8'h85);
    settle();
    chk("hext", 5'h08, hx);
    chk("vext", 5'h06, vx);
    chk("shape", 1'b1, shp);
    chk("under", 1'b0, und);
    rreg(CLO_REG_CURSOR_WIDTH, 8'h07);
    // Limits applied by the host, and graphics mode forcing the block shape.
    wreg(CLO_REG_CHAR_HSIZE, 8'h03);
    wreg(CLO_REG_CHAR_VSIZE, 8'h02);
    gmode <= 1'b1;
    wreg(CLO_REG_CURSOR_WIDTH, 8'h09);
    wreg(CLO_REG_CURSOR_HEIGHT, 8'h06);
    pulse(1'b1, CLO_CMD_SHAPE);
    settle();
    chk("hext", 5'h04, hx);
    chk("vext", 5'h03, vx);
    chk("shape", 1'b1, shp);
    // Block display types and the three-layer bit.
    wreg(CLO_REG_LAYER_SETUP, 8'h14);
    settle();
    chk("lcount", 2'h2, lc);
    chk("blocks", 4'hb, bg);
    wreg(CLO_REG_LAYER_SETUP, 8'h0b);
    l3 <= 1'b1;
    settle();
    chk("blocks", 4'he, bg);
    chk("pix", 1'b0, pix);
    rreg(CLO_REG_LAYER_SETUP, 8'h08);
    foreach (ROWS[i])
    begin
      wreg(CLO_REG_LAYER_SETUP, {6'h07, ROWS[i][5:4]});
      {l1, l2, l3} <= ROWS[i][3:1];
      settle();
      chk("pix", ROWS[i][0], pix);
      chk("lcount", 2'h3, lc);
    end
    // Layer command reloads the setup from the host's copy of the register.
    pulse(1'b1, CLO_CMD_LAYER);
    settle();
    chk("lcount", 2'h3, lc);
    chk("blocks", 4'hf, bg);
    rreg(CLO_REG_LAYER_SETUP, 8'h1e);
    // Cursor steps in all four directions with a nine pixel character.
    wreg(CLO_REG_CHAR_HSIZE, 8'h09);
    wreg(CLO_REG_PITCH_LO, 8'h28);
    wreg(CLO_REG_PITCH_HI, 8'h00);
    wreg(CLO_REG_CURSOR_LO, 8'h00);
    wreg(CLO_REG_CURSOR_HI, 8'h01);
    exp = 16'h0100;
    for (int d = 0; d < 4; d++)
    begin
      pulse(1'b1, CLO_CMD_STEP_BASE + 8'(d));
      pulse(1'b0, CLO_CMD_MEM);
      exp = d == 0 ? exp + 16'h0001 : d == 1 ? exp - 16'h0001 :
        d == 2 ? exp - 16'h0028 : exp + 16'h0028;
      settle();
      chk("caddr", exp, ca);
    end
    rreg(CLO_REG_CURSOR_STEP, 8'h03);
    // Direction set by a register write, unused bits dropped.
    wreg(CLO_REG_CURSOR_STEP, 8'hfd);
    pulse(1'b0, CLO_CMD_MEM);
    settle();
    chk("caddr", 16'h00ff, ca);
    rreg(CLO_REG_CURSOR_STEP, 8'h01);
    rreg(CLO_REG_CURSOR_RD_LO, 8'hff);
    rreg(CLO_REG_CURSOR_RD_HI, 8'h00);
    // Reset in mid-run.
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk("caddr", 16'h0000, ca);
    chk("lcount", 2'h2, lc);
    end_sim();
  end
endmodule : tb
`default_nettype wire
